// file: design/rssf_map.svh
// Purpose: Ramp spread register map.
// Assumes: Byte registers.
// Notes: Definitions only.
`ifndef RSSF_MAP_SVH
`define RSSF_MAP_SVH

// Register offsets.
`define RSSF_OFF_RAMP_PHASE_CONTROL 8'h6A
`define RSSF_OFF_SPREAD_ENABLE_CONTROL 8'h6B
`define RSSF_OFF_SPREAD_RANGE_CONTROL 8'h6C
`define RSSF_OFF_MANUAL_RAMP_FREQUENCY 8'h6D
`define RSSF_OFF_TRIANGLE_STEP_CONTROL 8'h6E
`define RSSF_OFF_RAMP_AMPLITUDE_BOUNDARY 8'h6F
`define RSSF_OFF_CHANNEL_FAULT_STATUS 8'h70
`define RSSF_OFF_GLOBAL_FAULT_STATUS_ONE 8'h71
`define RSSF_OFF_FAULT_MASK_CONTROL 8'h74
`define RSSF_OFF_FAULT_CLEAR_COMMAND 8'h78

// Reset values.
`define RSSF_RST_RAMP_PHASE_CONTROL 8'h00
`define RSSF_RST_SPREAD_ENABLE_CONTROL 8'h00
`define RSSF_RST_SPREAD_RANGE_CONTROL 8'h00
`define RSSF_RST_MANUAL_RAMP_FREQUENCY 8'h50
`define RSSF_RST_TRIANGLE_STEP_CONTROL 8'h11
`define RSSF_RST_RAMP_AMPLITUDE_BOUNDARY 8'h24
`define RSSF_RST_FAULT_MASK_CONTROL 8'h00

// Field positions.
`define RSSF_POS_PHASE_HI 3
`define RSSF_POS_PHASE_LO 2
`define RSSF_POS_I2S_SYNC 1
`define RSSF_POS_PHASE_SYNC 0
`define RSSF_POS_PREDIV 5
`define RSSF_POS_MANUAL 4
`define RSSF_POS_RDM_EN 1
`define RSSF_POS_TRI_EN 0
`define RSSF_POS_RDM_HI 6
`define RSSF_POS_RDM_LO 4
`define RSSF_POS_TRI_HI 3
`define RSSF_POS_TRI_LO 0
`define RSSF_POS_FALL_HI 7
`define RSSF_POS_FALL_LO 4
`define RSSF_POS_RISE_HI 3
`define RSSF_POS_RISE_LO 0
`define RSSF_POS_AMP_HI 6
`define RSSF_POS_AMP_LO 5
`define RSSF_POS_BOUND_HI 4
`define RSSF_POS_BOUND_LO 0
`define RSSF_POS_MASK_CLK 4
`define RSSF_POS_MASK_UV 3
`define RSSF_POS_MASK_OV 2
`define RSSF_POS_MASK_DC 1
`define RSSF_POS_MASK_OC 0
`define RSSF_POS_ANALOG_CLEAR 7

// Ramp and fault sizing.
`define RSSF_AUTO_DIVISOR 8'h50
`define RSSF_MIN_PERIOD 10'h002
`define RSSF_FAULT_COUNT 7
`define RSSF_LFSR_SEED 8'hA5

`endif

// file: design/rssf_pkg.sv
// Purpose: Ramp spread types.
// Assumes: None.
// Notes: Types only.
package rssf_pkg;

  typedef struct packed {
    logic [1:0] phase;
    logic i2s_sync;
    logic phase_sync;
    logic prediv;
    logic manual;
    logic rdm_en;
    logic tri_en;
    logic [2:0] rdm_range;
    logic [3:0] tri_ctrl;
    logic [7:0] divisor;
    logic [3:0] fall_step;
    logic [3:0] rise_step;
    logic [1:0] amplitude;
    logic [4:0] boundary;
  } rssf_ctrl_type;

  typedef struct packed {
    logic left_dc_fault;
    logic right_dc_fault;
    logic left_overcurrent_fault;
    logic right_overcurrent_fault;
    logic clock_fault;
    logic power_overvoltage_flag;
    logic power_undervoltage_flag;
  } rssf_fault_type;

  typedef enum logic {
    RSSF_HOLD,
    RSSF_RUN
  } rssf_ramp_state_type;

endpackage : rssf_pkg

// file: design/rssf_fault_bank.sv
// Purpose: Latches analog faults.
// Assumes: Asynchronous fault levels.
// Notes: Set wins over clear.
`timescale 1ns/100ps
`include "rssf_map.svh"
module rssf_fault_bank (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Fault sources and control.
  input wire logic [`RSSF_FAULT_COUNT-1:0] fault_raw,
  input wire logic [`RSSF_FAULT_COUNT-1:0] fault_mask,
  input wire logic clear_pulse,
  // Latched, masked view.
  output logic [`RSSF_FAULT_COUNT-1:0] fault_q
);

  genvar i;
  generate
    for (i = 0; i < `RSSF_FAULT_COUNT; i = i + 1) begin : g_fault
      logic meta_q;
      logic sync_q;
      logic held_q;
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= fault_raw[i];
          sync_q <= meta_q;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          held_q <= 1'b0;
        end else if (sync_q && !fault_mask[i]) begin
          held_q <= 1'b1;
        end else if (clear_pulse) begin
          held_q <= 1'b0;
        end
      end
      assign fault_q[i] = held_q && !fault_mask[i];
    end
  endgenerate

endmodule : rssf_fault_bank

// file: design/rssf_spread.sv
// Purpose: Spread period offset.
// Assumes: One advance per period.
// Notes: Offsets add.
`timescale 1ns/100ps
`include "rssf_map.svh"
module rssf_spread (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control.
  input wire logic advance,
  input wire rssf_pkg::rssf_ctrl_type ctrl,
  // Offset.
  output logic signed [7:0] offset_q
);

  logic signed [7:0] tri_q;
  logic signed [7:0] tri_d;
  logic up_q;
  logic [7:0] lfsr_q;
  logic signed [7:0] limit;
  logic signed [7:0] rise;
  logic signed [7:0] fall;
  logic signed [7:0] rnd;
  logic [7:0] rnd_mask;

  always_comb begin
    if (ctrl.manual) begin
      limit = {3'h0, ctrl.boundary};
      rise = {4'h0, ctrl.rise_step};
      fall = {4'h0, ctrl.fall_step};
    end else begin
      limit = {4'h0, ctrl.tri_ctrl} + 8'sh01;
      rise = 8'sh01;
      fall = 8'sh01;
    end
    rnd_mask = 8'(({1'b0, 8'h01} << ctrl.rdm_range) - 9'h001);
    rnd = $signed(lfsr_q & rnd_mask) - $signed({1'b0, rnd_mask[7:1]});
    tri_d = up_q ? tri_q + rise : tri_q - fall;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tri_q <= 8'sh00;
      up_q <= 1'b1;
    end else if (!ctrl.tri_en) begin
      tri_q <= 8'sh00;
      up_q <= 1'b1;
    end else if (advance) begin
      if (up_q && tri_d >= limit) begin
        tri_q <= limit;
        up_q <= 1'b0;
      end else if (!up_q && tri_d <= -limit) begin
        tri_q <= -limit;
        up_q <= 1'b1;
      end else begin
        tri_q <= tri_d;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lfsr_q <= `RSSF_LFSR_SEED;
    end else if (advance) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      offset_q <= 8'sh00;
    end else begin
      offset_q <= (ctrl.tri_en ? tri_q : 8'sh00) + (ctrl.rdm_en ? rnd : 8'sh00);
    end
  end

endmodule : rssf_spread

// file: design/rssf_top.sv
// Purpose: Ramp control, ramp generator and fault status.
// Assumes: Byte control port on clk_sys.
// Notes: Sync and fault_raw pins pass two flip-flops.
//
// Contract
// - Two-bit phase field picks one of four ramp clock phases.
// - Serial-audio sync enable aligns the ramp to the audio frame timing.
// - Ramp phase sync enable turns ramp phase synchronisation on.
// - Manual predivider select runs the ramp from half the source clock.
// - Manual mode bit makes frequency, step, amplitude and boundary fields act.
// - Bit 1 enables random spread; three-bit field sets its range.
// - Bit 0 enables triangle spread; four-bit field sets its rate and range.
// - Manual ramp period is the eight-bit divisor, reset 0x50.
// - Upper nibble sets the triangle falling step, reset 0001.
// - Lower nibble sets the triangle rising step, reset 0001.
// - Two-bit field sets ramp amplitude, reset 01.
// - Five-bit field sets the triangle period boundary, reset 00100.
// - Channel fault bits 3 and 2 report left and right DC faults.
// - Channel fault bits 1 and 0 report left and right over-current.
// - Global fault bit 7 reports a failed one-time memory CRC check.
// - Global fault bit 6 reports a failed last biquad write.
// - Writing one to the analog clear bit clears latched analog faults.
// - A set mask bit stops its fault from being reported.
`timescale 1ns/100ps
`include "rssf_map.svh"
module rssf_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Internal control port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic reg_rvalid_q,
  // Play request from the power state logic.
  input wire logic ramp_run,
  // Asynchronous sync pins.
  input wire logic audio_frame_sync,
  input wire logic ramp_sync_in,
  // Fault sources.
  input wire rssf_pkg::rssf_fault_type fault_raw,
  input wire logic otp_crc_error,
  input wire logic biquad_write_failure,
  // Ramp and fault outputs.
  output logic ramp_clk_q,
  output logic ramp_tick_q,
  output logic [1:0] ramp_amplitude_q,
  output logic fault_any_q
);

  logic [7:0] ramp_phase_control_q;
  logic [7:0] spread_enable_control_q;
  logic [7:0] spread_range_control_q;
  logic [7:0] manual_ramp_frequency_q;
  logic [7:0] triangle_step_control_q;
  logic [7:0] ramp_amplitude_boundary_q;
  logic [7:0] fault_mask_control_q;
  logic analog_clear_q;
  rssf_pkg::rssf_ctrl_type ctrl;
  logic [`RSSF_FAULT_COUNT-1:0] fault_mask;
  logic [`RSSF_FAULT_COUNT-1:0] fault_view;
  rssf_pkg::rssf_fault_type faults;
  logic [7:0] channel_fault_status;
  logic [7:0] global_fault_status_one;
  logic [7:0] rdata_d;
  logic frame_meta_q;
  logic frame_sync_q;
  logic frame_last_q;
  logic ramp_meta_q;
  logic ramp_sync_q;
  logic ramp_last_q;
  logic sync_event;
  logic half_rate_q;
  logic step_en;
  logic signed [7:0] spread_offset;
  logic [7:0] base_divisor;
  logic [9:0] period_raw;
  logic [9:0] period;
  logic [9:0] quarter;
  logic [9:0] phase_offset;
  logic [9:0] count_q;
  logic [9:0] count_d;
  logic wrap;
  rssf_pkg::rssf_ramp_state_type state_q;

  // Register writes.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ramp_phase_control_q <= `RSSF_RST_RAMP_PHASE_CONTROL;
      spread_enable_control_q <= `RSSF_RST_SPREAD_ENABLE_CONTROL;
      spread_range_control_q <= `RSSF_RST_SPREAD_RANGE_CONTROL;
      manual_ramp_frequency_q <= `RSSF_RST_MANUAL_RAMP_FREQUENCY;
      triangle_step_control_q <= `RSSF_RST_TRIANGLE_STEP_CONTROL;
      ramp_amplitude_boundary_q <= `RSSF_RST_RAMP_AMPLITUDE_BOUNDARY;
      fault_mask_control_q <= `RSSF_RST_FAULT_MASK_CONTROL;
    end else if (reg_wr) begin
      case (reg_addr)
        `RSSF_OFF_RAMP_PHASE_CONTROL: ramp_phase_control_q <= reg_wdata;
        `RSSF_OFF_SPREAD_ENABLE_CONTROL: spread_enable_control_q <= reg_wdata;
        `RSSF_OFF_SPREAD_RANGE_CONTROL: spread_range_control_q <= reg_wdata;
        `RSSF_OFF_MANUAL_RAMP_FREQUENCY: manual_ramp_frequency_q <= reg_wdata;
        `RSSF_OFF_TRIANGLE_STEP_CONTROL: triangle_step_control_q <= reg_wdata;
        `RSSF_OFF_RAMP_AMPLITUDE_BOUNDARY: ramp_amplitude_boundary_q <= reg_wdata;
        `RSSF_OFF_FAULT_MASK_CONTROL: fault_mask_control_q <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Clear command pulse, never stored.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      analog_clear_q <= 1'b0;
    end else begin
      analog_clear_q <= reg_wr && (reg_addr == `RSSF_OFF_FAULT_CLEAR_COMMAND) &&
                        reg_wdata[`RSSF_POS_ANALOG_CLEAR];
    end
  end

  // Field decode.
  always_comb begin
    ctrl.phase = ramp_phase_control_q[`RSSF_POS_PHASE_HI:`RSSF_POS_PHASE_LO];
    ctrl.i2s_sync = ramp_phase_control_q[`RSSF_POS_I2S_SYNC];
    ctrl.phase_sync = ramp_phase_control_q[`RSSF_POS_PHASE_SYNC];
    ctrl.prediv = spread_enable_control_q[`RSSF_POS_PREDIV];
    ctrl.manual = spread_enable_control_q[`RSSF_POS_MANUAL];
    ctrl.rdm_en = spread_enable_control_q[`RSSF_POS_RDM_EN];
    ctrl.tri_en = spread_enable_control_q[`RSSF_POS_TRI_EN];
    ctrl.rdm_range = spread_range_control_q[`RSSF_POS_RDM_HI:`RSSF_POS_RDM_LO];
    ctrl.tri_ctrl = spread_range_control_q[`RSSF_POS_TRI_HI:`RSSF_POS_TRI_LO];
    ctrl.divisor = manual_ramp_frequency_q;
    ctrl.fall_step = triangle_step_control_q[`RSSF_POS_FALL_HI:`RSSF_POS_FALL_LO];
    ctrl.rise_step = triangle_step_control_q[`RSSF_POS_RISE_HI:`RSSF_POS_RISE_LO];
    ctrl.amplitude = ramp_amplitude_boundary_q[`RSSF_POS_AMP_HI:`RSSF_POS_AMP_LO];
    ctrl.boundary = ramp_amplitude_boundary_q[`RSSF_POS_BOUND_HI:`RSSF_POS_BOUND_LO];
  end

  // Mask bits per fault source.
  assign fault_mask = {
    fault_mask_control_q[`RSSF_POS_MASK_DC],
    fault_mask_control_q[`RSSF_POS_MASK_DC],
    fault_mask_control_q[`RSSF_POS_MASK_OC],
    fault_mask_control_q[`RSSF_POS_MASK_OC],
    fault_mask_control_q[`RSSF_POS_MASK_CLK],
    fault_mask_control_q[`RSSF_POS_MASK_OV],
    fault_mask_control_q[`RSSF_POS_MASK_UV]
  };

  rssf_fault_bank u_fault_bank (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fault_raw(fault_raw),
    .fault_mask(fault_mask),
    .clear_pulse(analog_clear_q),
    .fault_q(fault_view)
  );

  assign faults = fault_view;

  // Status words; reserved bits read zero.
  assign channel_fault_status = {4'h0, faults.left_dc_fault, faults.right_dc_fault,
                                 faults.left_overcurrent_fault,
                                 faults.right_overcurrent_fault};
  assign global_fault_status_one = {otp_crc_error, biquad_write_failure, 3'h0,
                                    faults.clock_fault, faults.power_overvoltage_flag,
                                    faults.power_undervoltage_flag};

  // Read mux; unmapped and write-only offsets read zero.
  always_comb begin
    case (reg_addr)
      `RSSF_OFF_RAMP_PHASE_CONTROL: rdata_d = ramp_phase_control_q;
      `RSSF_OFF_SPREAD_ENABLE_CONTROL: rdata_d = spread_enable_control_q;
      `RSSF_OFF_SPREAD_RANGE_CONTROL: rdata_d = spread_range_control_q;
      `RSSF_OFF_MANUAL_RAMP_FREQUENCY: rdata_d = manual_ramp_frequency_q;
      `RSSF_OFF_TRIANGLE_STEP_CONTROL: rdata_d = triangle_step_control_q;
      `RSSF_OFF_RAMP_AMPLITUDE_BOUNDARY: rdata_d = ramp_amplitude_boundary_q;
      `RSSF_OFF_CHANNEL_FAULT_STATUS: rdata_d = channel_fault_status;
      `RSSF_OFF_GLOBAL_FAULT_STATUS_ONE: rdata_d = global_fault_status_one;
      `RSSF_OFF_FAULT_MASK_CONTROL: rdata_d = fault_mask_control_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rdata_d;
      end
    end
  end

  // Sync pin synchronisers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_meta_q <= 1'b0;
      frame_sync_q <= 1'b0;
      frame_last_q <= 1'b0;
      ramp_meta_q <= 1'b0;
      ramp_sync_q <= 1'b0;
      ramp_last_q <= 1'b0;
    end else begin
      frame_meta_q <= audio_frame_sync;
      frame_sync_q <= frame_meta_q;
      frame_last_q <= frame_sync_q;
      ramp_meta_q <= ramp_sync_in;
      ramp_sync_q <= ramp_meta_q;
      ramp_last_q <= ramp_sync_q;
    end
  end

  assign sync_event = (ctrl.i2s_sync && frame_sync_q && !frame_last_q) ||
                      (ctrl.phase_sync && ramp_sync_q && !ramp_last_q);

  // Half-rate stepping for the predivider.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      half_rate_q <= 1'b0;
    end else begin
      half_rate_q <= !half_rate_q;
    end
  end

  assign step_en = !(ctrl.manual && ctrl.prediv) || half_rate_q;

  rssf_spread u_spread (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .advance(wrap && step_en),
    .ctrl(ctrl),
    .offset_q(spread_offset)
  );

  // Ramp period and phase offset.
  always_comb begin
    base_divisor = ctrl.manual ? ctrl.divisor : `RSSF_AUTO_DIVISOR;
    period_raw = 10'({2'b00, base_divisor} + {{2{spread_offset[7]}}, spread_offset});
    if (spread_offset[7] && ({2'b00, base_divisor} < 10'(-$signed({{2{spread_offset[7]}},
        spread_offset})))) begin
      period = `RSSF_MIN_PERIOD;
    end else if (period_raw < `RSSF_MIN_PERIOD) begin
      period = `RSSF_MIN_PERIOD;
    end else begin
      period = period_raw;
    end
    quarter = {2'b00, period[9:2]};
    case (ctrl.phase)
      2'h0: phase_offset = 10'h000;
      2'h1: phase_offset = quarter;
      2'h2: phase_offset = 10'(quarter << 1);
      2'h3: phase_offset = 10'(quarter + (quarter << 1));
      default: phase_offset = 10'h000;
    endcase
  end

  assign wrap = (count_q >= period - 10'h001);
  assign count_d = wrap ? 10'h000 : 10'(count_q + 10'h001);

  // Ramp state; phase offset loads on start and sync.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= rssf_pkg::RSSF_HOLD;
      count_q <= 10'h000;
    end else begin
      case (state_q)
        rssf_pkg::RSSF_HOLD: begin
          count_q <= phase_offset;
          if (ramp_run) begin
            state_q <= rssf_pkg::RSSF_RUN;
          end
        end
        rssf_pkg::RSSF_RUN: begin
          if (!ramp_run) begin
            state_q <= rssf_pkg::RSSF_HOLD;
          end else if (sync_event) begin
            count_q <= phase_offset;
          end else if (step_en) begin
            count_q <= count_d;
          end
        end
        default: begin
          state_q <= rssf_pkg::RSSF_HOLD;
        end
      endcase
    end
  end

  // Ramp and fault outputs.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ramp_clk_q <= 1'b0;
      ramp_tick_q <= 1'b0;
      ramp_amplitude_q <= 2'h0;
      fault_any_q <= 1'b0;
    end else begin
      ramp_clk_q <= (state_q == rssf_pkg::RSSF_RUN) && (count_q < {1'b0, period[9:1]});
      ramp_tick_q <= (state_q == rssf_pkg::RSSF_RUN) && ramp_run && !sync_event &&
                     step_en && wrap;
      ramp_amplitude_q <= ctrl.manual ? ctrl.amplitude : 2'h1;
      fault_any_q <= |fault_view;
    end
  end

endmodule : rssf_top

// file: testbench/rssf_properties.sv
// Purpose: Port checks.
// Assumes: Shadows track writes.
// Notes: Bound to rssf_top.
`timescale 1ns/100ps
module rssf_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic reg_rvalid_q,
  // Ramp and fault pins.
  input wire logic ramp_run,
  input wire rssf_pkg::rssf_fault_type fault_raw,
  input wire logic otp_crc_error,
  input wire logic biquad_write_failure,
  input wire logic ramp_tick_q,
  input wire logic [1:0] ramp_amplitude_q,
  input wire logic fault_any_q
);
  logic [7:0] sh_q [0:5];
  logic [7:0] mask_q;
  logic [9:0] cnt_q, exp_per;
  logic ok_q, rw_hit, plain;
  logic [7:0] sh_rd;
  logic [1:0] exp_amp;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sh_q <= '{8'h00, 8'h00, 8'h00, 8'h50, 8'h11, 8'h24};
      mask_q <= 8'h00;
    end else if (reg_wr && rw_hit) begin
      sh_q[3'(reg_addr - 8'h6A)] <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h74) begin
      mask_q <= reg_wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n || ramp_tick_q) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_q + 10'h001;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !ramp_run || reg_wr) begin
      ok_q <= 1'b0;
    end else if (ramp_tick_q) begin
      ok_q <= 1'b1;
    end
  end
  always_comb begin
    rw_hit = reg_addr >= 8'h6A && reg_addr <= 8'h6F;
    sh_rd = sh_q[3'(reg_addr - 8'h6A)];
    exp_amp = sh_q[1][4] ? sh_q[5][6:5] : 2'h1;
    exp_per = !sh_q[1][4] ? 10'h050 : (sh_q[1][5] ? {1'b0, sh_q[3], 1'b0} : {2'h0, sh_q[3]});
    plain = sh_q[1][1:0] == 2'h0 && sh_q[0][1:0] == 2'h0 && sh_q[3] >= 8'h02;
  end
  sequence s_uv_held;
    (fault_raw.power_undervoltage_flag && !mask_q[3])[*5];
  endsequence
  sequence s_quiet;
    (fault_raw == 7'h00)[*3];
  endsequence
  sequence s_clear;
    reg_wr && reg_addr == 8'h78 && reg_wdata[7];
  endsequence
  property p_rvalid;
    reg_rvalid_q == $past(reg_rd);
  endproperty
  property p_rw_read;
    logic [7:0] v;
    (reg_rd && rw_hit, v = sh_rd) |=> reg_rdata_q == v;
  endproperty
  property p_chan;
    reg_rd && reg_addr == 8'h70 |=> reg_rdata_q[7:4] == 4'h0;
  endproperty
  property p_glob;
    logic a;
    logic b;
    (reg_rd && reg_addr == 8'h71, a = otp_crc_error, b = biquad_write_failure)
      |=> reg_rdata_q[7:3] == {a, b, 3'h0};
  endproperty
  property p_unmapped;
    reg_rd && !(reg_addr inside {[8'h6A:8'h71], 8'h74}) |=> reg_rdata_q == 8'h00;
  endproperty
  property p_set;
    s_uv_held |-> fault_any_q;
  endproperty
  property p_clear;
    s_quiet ##0 s_clear ##1 s_quiet |=> !fault_any_q;
  endproperty
  property p_amp;
    $stable(exp_amp)[*3] |-> ramp_amplitude_q == exp_amp;
  endproperty
  property p_tick;
    ramp_tick_q |=> !ramp_tick_q;
  endproperty
  property p_period;
    ramp_tick_q && ok_q && plain |-> cnt_q == exp_per - 10'h001;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("rvalid late");
  a_rw_read: assert property (p_rw_read) else $error("rw read");
  a_chan: assert property (p_chan) else $error("chan resv");
  a_glob: assert property (p_glob) else $error("glob bits");
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  a_set: assert property (p_set) else $error("fault set");
  a_clear: assert property (p_clear) else $error("fault clear");
  a_amp: assert property (p_amp) else $error("amplitude");
  a_tick: assert property (p_tick) else $error("tick width");
  a_period: assert property (p_period) else $error("period");
endmodule : rssf_checker

bind rssf_top rssf_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .ramp_run(ramp_run), .fault_raw(fault_raw),
  .otp_crc_error(otp_crc_error), .biquad_write_failure(biquad_write_failure),
  .ramp_tick_q(ramp_tick_q), .ramp_amplitude_q(ramp_amplitude_q), .fault_any_q(fault_any_q)
);

// file: testbench/rssf_tb.sv
// Purpose: Self-checking bench.
// Assumes: Falling edge stimulus.
// Notes: Rows first, then ramp cases.
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [1:0] k;
    logic [7:0] a;
    logic [7:0] d;
  } rssf_row_type;
  localparam logic [1:0] kr = 2'h0, kw = 2'h1, kf = 2'h2, ko = 2'h3;
  localparam rssf_row_type rows [0:53] = '{
    {kr,8'h6A,8'h00}, {kr,8'h6B,8'h00}, {kr,8'h6C,8'h00}, {kr,8'h6D,8'h50}, {kr,8'h6E,8'h11},
    {kr,8'h6F,8'h24}, {kr,8'h70,8'h00}, {kr,8'h71,8'h00}, {kr,8'h74,8'h00}, {kr,8'h78,8'h00},
    {kr,8'h90,8'h00}, {kw,8'h6A,8'hFF}, {kr,8'h6A,8'hFF}, {kw,8'h6A,8'h00}, {kw,8'h6E,8'hA5},
    {kr,8'h6E,8'hA5}, {kw,8'h6E,8'h11}, {kw,8'h70,8'hFF}, {kr,8'h70,8'h00}, {kf,8'h00,8'h50},
    {kr,8'h70,8'h0A}, {kf,8'h00,8'h28}, {kr,8'h70,8'h0F}, {kf,8'h00,8'h00}, {kw,8'h78,8'h80},
    {kr,8'h70,8'h00}, {kf,8'h00,8'h05}, {kr,8'h71,8'h05}, {kf,8'h00,8'h02}, {kr,8'h71,8'h07},
    {kf,8'h00,8'h00}, {kw,8'h78,8'h80}, {kr,8'h71,8'h00}, {kw,8'h74,8'h1F}, {kf,8'h00,8'h7F},
    {kr,8'h70,8'h00}, {kr,8'h71,8'h00}, {kw,8'h74,8'h1D}, {kr,8'h70,8'h0C}, {kr,8'h71,8'h00},
    {kw,8'h74,8'h00}, {kr,8'h70,8'h0F}, {kr,8'h71,8'h07}, {kw,8'h78,8'h80}, {kr,8'h71,8'h07},
    {kf,8'h00,8'h00}, {kw,8'h78,8'h80}, {kr,8'h70,8'h00}, {kr,8'h71,8'h00}, {ko,8'h00,8'h02},
    {kr,8'h71,8'h80}, {ko,8'h00,8'h01}, {kr,8'h71,8'h40}, {ko,8'h00,8'h00}};
  logic clk_sys, rst_n, reg_wr, reg_rd, reg_rvalid_q, ramp_run;
  logic audio_frame_sync, ramp_sync_in, otp_crc_error, biquad_write_failure;
  logic ramp_clk_q, ramp_tick_q, fault_any_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic [1:0] ramp_amplitude_q;
  rssf_pkg::rssf_fault_type fault_raw;
  int miscompares = 0;
  int check_count = 0;
  rssf_top dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .ramp_run(ramp_run), .audio_frame_sync(audio_frame_sync),
    .ramp_sync_in(ramp_sync_in), .fault_raw(fault_raw), .otp_crc_error(otp_crc_error),
    .biquad_write_failure(biquad_write_failure), .ramp_clk_q(ramp_clk_q),
    .ramp_tick_q(ramp_tick_q), .ramp_amplitude_q(ramp_amplitude_q), .fault_any_q(fault_any_q)
  );
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chk_n(input string n, input int e, input int g);
    check_count++;
    if (g != e) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_n
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    chk8("read valid", 8'h01, {7'h00, reg_rvalid_q});
    d = reg_rdata_q;
  endtask : rd
  task automatic tick_wait(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (ramp_tick_q !== 1'b1 && n < 400);
    if (n >= 400) begin
      chk_n("tick wait", 0, n);
    end
  endtask : tick_wait
  task automatic sync_delay(input int p, input int g, output int d);
    int n;
    ramp_run = 1'b1;
    tick_wait(n);
    repeat (g) @(negedge clk_sys);
    audio_frame_sync = (p == 1);
    ramp_sync_in = (p == 0);
    tick_wait(d);
    audio_frame_sync = 1'b0;
    ramp_sync_in = 1'b0;
    ramp_run = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : sync_delay
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  initial begin
    logic [7:0] v;
    int n, d5, d10, vary;
    int dl [0:3];
    static int cfg [0:3] = '{'h00, 'h10, 'h30, 'h20};
    static int per [0:3] = '{80, 16, 32, 80};
    {rst_n, reg_wr, reg_rd, ramp_run, audio_frame_sync, ramp_sync_in} = 6'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    fault_raw = 7'h00;
    {otp_crc_error, biquad_write_failure} = 2'h0;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    foreach (rows[i]) begin
      case (rows[i].k)
        kr: begin
          rd(rows[i].a, v);
          chk8($sformatf("reg %h", rows[i].a), rows[i].d, v);
        end
        kw: wr(rows[i].a, rows[i].d);
        kf: begin
          fault_raw = rows[i].d[6:0];
          repeat (6) @(negedge clk_sys);
        end
        default: {otp_crc_error, biquad_write_failure} = rows[i].d[1:0];
      endcase
      @(negedge clk_sys);
    end
    $display("Test done: register rows");
    wr(8'h6D, 8'h33);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    rd(8'h6D, v);
    chk8("divisor after reset", 8'h50, v);
    $display("Test done: reset");
    wr(8'h6B, 8'h10);
    wr(8'h6F, 8'h40);
    repeat (3) @(negedge clk_sys);
    chk8("manual amplitude", 8'h02, {6'h00, ramp_amplitude_q});
    wr(8'h6B, 8'h00);
    repeat (3) @(negedge clk_sys);
    chk8("auto amplitude", 8'h01, {6'h00, ramp_amplitude_q});
    $display("Test done: amplitude");
    wr(8'h6D, 8'h10);
    for (int c = 0; c < 4; c++) begin
      wr(8'h6B, 8'(cfg[c]));
      ramp_run = 1'b1;
      tick_wait(n);
      tick_wait(n);
      chk_n("ramp period", per[c], n);
      chk8("ramp clock low", 8'h00, {7'h00, ramp_clk_q});
      @(negedge clk_sys);
      chk8("ramp clock high", 8'h01, {7'h00, ramp_clk_q});
      ramp_run = 1'b0;
      repeat (4) @(negedge clk_sys);
    end
    $display("Test done: period");
    wr(8'h6B, 8'h10);
    for (int k = 0; k < 4; k++) begin
      wr(8'h6A, 8'(k * 4));
      ramp_run = 1'b1;
      tick_wait(dl[k]);
      ramp_run = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk_n("phase shift", 4 * k, dl[0] - dl[k]);
    end
    $display("Test done: phase");
    wr(8'h6D, 8'h20);
    for (int p = 0; p < 2; p++) begin
      for (int c = 1; c < 3; c++) begin
        wr(8'h6A, 8'(c));
        sync_delay(p, 5, d5);
        sync_delay(p, 10, d10);
        chk_n("sync delay change", (c == p + 1) ? 0 : 5, d5 - d10);
      end
    end
    $display("Test done: sync");
    wr(8'h6A, 8'h00);
    wr(8'h6C, 8'h7F);
    for (int s = 1; s < 3; s++) begin
      wr(8'h6B, 8'(s));
      ramp_run = 1'b1;
      tick_wait(n);
      vary = 0;
      repeat (6) begin
        tick_wait(n);
        vary += (n != 80);
      end
      chk_n("spread varies period", 1, int'(vary > 0));
      ramp_run = 1'b0;
      repeat (4) @(negedge clk_sys);
    end
    $display("Test done: spread");
    end_sim();
  end
endmodule : tb
